// File: include/sac_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  converter control block.
  Assumes a 20-bit AXI4-Lite byte address space and 32-bit data.
*/
// Notes on behaviour
// R1: six analog channels, 10-bit result, selected channel converted repeatedly.
// R2: every finished conversion raises the conversion-done interrupt request.
// R3: pins not selected as analog input stay usable as port pins.
// R4: first step sets top approximation bit when input is at or above half reference.
// R5: then bit 10 is set and compared against quarter or three-quarter tap.
// R6: each trial bit kept when input at or above tap; down to bit 0.
// R7: approximation register is 12 bits, resolved one bit per step, MSB first.
// R8: after the last bit, approximation value moves to the wide result.
// R9: wide result holds result in upper 10 bits, low 6 read zero.
// R10: narrow result loads upper 8 bits of the 10-bit result each time.
// R11: software sets clock-gate bit 5 before using the converter.
// R12: gate off stops clock, resets converter, ignores writes, reads defaults.
// R13: port configuration write with gate off is dropped; register reinitialised.
// R14: software writes zero to bits 6 and 7 of the gate register.
// R15: gate register takes byte writes and resets to 00H.
// R16: mode register takes byte writes and resets to 00H.
// R17: run bit 0 stops conversion, 1 enables continuous conversion.
// R18: comparator enable 0 stops the voltage comparator.
// R19: software waits 1 us after comparator enable before setting run.
// R20: run without comparator enable is prohibited; comparator-only is waiting.
// R21: wide and narrow results update together from the same conversion.
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ----------------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------------
`define SAC_OFS_GATE       20'hF00F0
`define SAC_OFS_MODE       20'hF0100
`define SAC_OFS_PCFG       20'hF0104
`define SAC_OFS_CHSEL      20'hF0108
`define SAC_OFS_RWIDE      20'hF010C
`define SAC_OFS_RNARROW    20'hF0110

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define SAC_GATE_CLK_BIT   5
`define SAC_MODE_RUN_BIT   7
`define SAC_MODE_CMP_BIT   0
`define SAC_GATE_RST       6'h00
`define SAC_MODE_RST       8'h00
`define SAC_PCFG_RST       6'h00
`define SAC_CHSEL_RST      3'h0
`define SAC_RWIDE_RST      16'h0000
`define SAC_RNARROW_RST    8'h00
`define SAC_SAR_MSB_SET    12'h800
`define SAC_SAR_TOP_IDX    4'hB

// ----------------------------------------------------------------------
// timing and bus answers
// ----------------------------------------------------------------------
`define SAC_STEP_CYCLES    20
`define SAC_RESP_OKAY      2'h0
`define SAC_RESP_SLVERR    2'h2

`endif

// File: include/sac_pkg.sv
/*
  Types of the converter control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sac_pkg;

  // ----------------------------------------------------------------------
  // conversion sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_CONVERT
  } sac_state_t;

endpackage

// File: rtl/sac_top.sv
/*
  Converter control block: AXI4-Lite slave, approximation sequencer, results.
  Assumes an analog array turning tap_code into a tap voltage and a comparator
  (async to core_clk) that is high while the held input is at or above it.
*/
`timescale 1ns/1ps
`include "sac_regs.svh"
module sac_top
  import sac_pkg::*;
#(
  parameter int ADDR_W      = 20,
  parameter int STEP_CYCLES = `SAC_STEP_CYCLES,
  parameter int CHANNELS    = 6
) (
  input  wire logic                core_clk,        // system clock
  input  wire logic                rst,             // sync reset
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,    // write address
  input  wire logic                s_axi_awvalid,   // write address valid
  output logic                     s_axi_awready,   // write address ready
  input  wire logic [31:0]         s_axi_wdata,     // write data
  input  wire logic [3:0]          s_axi_wstrb,     // write strobes
  input  wire logic                s_axi_wvalid,    // write data valid
  output logic                     s_axi_wready,    // write data ready
  output logic [1:0]               s_axi_bresp,     // write response
  output logic                     s_axi_bvalid,    // write response valid
  input  wire logic                s_axi_bready,    // write response ready
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,    // read address
  input  wire logic                s_axi_arvalid,   // read address valid
  output logic                     s_axi_arready,   // read address ready
  output logic [31:0]              s_axi_rdata,     // read data
  output logic [1:0]               s_axi_rresp,     // read response
  output logic                     s_axi_rvalid,    // read data valid
  input  wire logic                s_axi_rready,    // read data ready
  input  wire logic                cmp_at_or_above, // comparator output
  output logic [11:0]              tap_code,        // approximation_reg
  output logic                     sample_hold,     // sample phase
  output logic [CHANNELS-1:0]      analog_inputs,   // pin to analog mux
  output logic                     comparator_on,   // comparator powered
  output logic                     converter_clk_en, // converter clock on
  output logic                     conversion_done_irq // done pulse
);
  localparam int CNT_W = $clog2(STEP_CYCLES + 1);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);
  // ----------------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------------
  logic              awready_q;
  logic              wready_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              wr_fire;
  logic              wr_byte0;
  assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
  assign wr_byte0 = wr_fire && wstrb_q[0];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end else if (s_axi_awvalid && awready_q) begin
      aw_have_q <= 1'b1;
      awready_q <= 1'b0;
      awaddr_q  <= s_axi_awaddr;
    end else if (!aw_have_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end else if (s_axi_wvalid && wready_q) begin
      w_have_q <= 1'b1;
      wready_q <= 1'b0;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (!w_have_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `SAC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= addr_known(awaddr_q) ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = (a == `SAC_OFS_GATE) || (a == `SAC_OFS_MODE) ||
                 (a == `SAC_OFS_PCFG) || (a == `SAC_OFS_CHSEL) ||
                 (a == `SAC_OFS_RWIDE) || (a == `SAC_OFS_RNARROW);
  endfunction
  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  logic [5:0] gate_q;
  logic [7:0] mode_q;
  logic [5:0] pcfg_q;
  logic [2:0] chsel_q;
  logic       gate_on;
  logic       run_on;
  logic       cmp_en;
  assign gate_on = gate_q[`SAC_GATE_CLK_BIT];
  assign run_on  = mode_q[`SAC_MODE_RUN_BIT];
  assign cmp_en  = mode_q[`SAC_MODE_CMP_BIT];
  // bits 7:6 are not stored and read as zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gate_q <= `SAC_GATE_RST;                                   // [R15]
    end else if (wr_byte0 && awaddr_q == `SAC_OFS_GATE) begin
      gate_q <= wdata_q[5:0];                                    // [R15]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !gate_on) begin
      mode_q <= `SAC_MODE_RST;                                   // [R12] [R16]
    end else if (wr_byte0 && awaddr_q == `SAC_OFS_MODE) begin
      mode_q <= wdata_q[7:0];                                    // [R16]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !gate_on) begin
      pcfg_q <= `SAC_PCFG_RST;                                   // [R13]
    end else if (wr_byte0 && awaddr_q == `SAC_OFS_PCFG) begin
      pcfg_q <= wdata_q[5:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !gate_on) begin
      chsel_q <= `SAC_CHSEL_RST;                                 // [R12]
    end else if (wr_byte0 && awaddr_q == `SAC_OFS_CHSEL) begin
      chsel_q <= wdata_q[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------------
  logic cmp_s1_q;
  logic cmp_s2_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= cmp_at_or_above;
      cmp_s2_q <= cmp_s1_q;
    end
  end
  // ----------------------------------------------------------------------
  // successive approximation sequencer
  // ----------------------------------------------------------------------
  sac_state_t     state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0]     idx_q;
  logic [11:0]    sar_q;
  logic           sample_q;
  logic           active;
  logic           step_end;
  logic           conv_done;
  logic [11:0]    sar_final;
  assign active    = gate_on && run_on && cmp_en;                // [R17] [R20]
  assign step_end  = (cnt_q == STEP_LAST);
  // an aborted conversion (active low) loads no result
  assign conv_done = active && (state_q == SAC_CONVERT) && step_end &&
                     (idx_q == 4'h0);
  assign sar_final = {sar_q[11:1], cmp_s2_q};
  always_ff @(posedge core_clk) begin
    if (rst || !active) begin
      state_q  <= SAC_IDLE;                                      // [R17]
      cnt_q    <= '0;
      idx_q    <= 4'h0;
      sar_q    <= 12'h000;
      sample_q <= 1'b0;
    end else begin
      case (state_q)
        SAC_IDLE: begin
          state_q  <= SAC_SAMPLE;
          cnt_q    <= '0;
          sample_q <= 1'b1;
        end
        SAC_SAMPLE: begin
          if (step_end) begin
            state_q  <= SAC_CONVERT;
            sample_q <= 1'b0;
            cnt_q    <= '0;
            idx_q    <= `SAC_SAR_TOP_IDX;                        // [R7]
            sar_q    <= `SAC_SAR_MSB_SET;                        // [R4]
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        SAC_CONVERT: begin
          if (!step_end) begin
            cnt_q <= cnt_q + 1'b1;
          end else if (idx_q == 4'h0) begin
            state_q  <= SAC_SAMPLE;                              // [R1]
            sample_q <= 1'b1;
            cnt_q    <= '0;
            sar_q    <= 12'h000;
          end else begin
            cnt_q              <= '0;
            sar_q[idx_q]       <= cmp_s2_q;                      // [R4] [R6]
            sar_q[idx_q - 4'h1] <= 1'b1;                         // [R5] [R6]
            idx_q              <= idx_q - 4'h1;                  // [R7]
          end
        end
        default: begin
          state_q <= SAC_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // results and completion pulse
  // ----------------------------------------------------------------------
  logic [15:0] wide_q;
  logic [7:0]  narrow_q;
  logic        irq_q;
  always_ff @(posedge core_clk) begin
    if (rst || !gate_on) begin
      wide_q   <= `SAC_RWIDE_RST;
      narrow_q <= `SAC_RNARROW_RST;
    end else if (conv_done) begin
      wide_q   <= {sar_final[11:2], 6'h00};                      // [R8] [R9] [R21]
      narrow_q <= sar_final[11:4];                               // [R10] [R21]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= conv_done;                                        // [R2]
    end
  end

  // ----------------------------------------------------------------------
  // analog side controls
  // ----------------------------------------------------------------------
  logic [CHANNELS-1:0] ana_q;
  logic                cmp_on_q;
  logic                clk_en_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ana_q    <= '0;
      cmp_on_q <= 1'b0;
      clk_en_q <= 1'b0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        // only the selected analog pin leaves port use
        ana_q[i] <= gate_on && pcfg_q[i] && (chsel_q == 3'(i)); // [R1] [R3]
      end
      cmp_on_q <= gate_on && cmp_en;                             // [R18]
      clk_en_q <= gate_on;                                       // [R12]
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `SAC_OFS_GATE:    rd_mux = {26'h0, gate_q};
      `SAC_OFS_MODE:    rd_mux = {24'h0, mode_q};
      `SAC_OFS_PCFG:    rd_mux = {26'h0, pcfg_q};
      `SAC_OFS_CHSEL:   rd_mux = {29'h0, chsel_q};
      `SAC_OFS_RWIDE:   rd_mux = {16'h0, wide_q};
      `SAC_OFS_RNARROW: rd_mux = {24'h0, narrow_q};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `SAC_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= addr_known(s_axi_araddr) ? `SAC_RESP_OKAY
                                            : `SAC_RESP_SLVERR;
    end else if (rvalid_q) begin
      if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end else begin
      arready_q <= 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign tap_code            = sar_q;
  assign sample_hold         = sample_q;
  assign analog_inputs       = ana_q;
  assign comparator_on       = cmp_on_q;
  assign converter_clk_en    = clk_en_q;
  assign conversion_done_irq = irq_q;
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_irq_one_cycle;
    @(posedge core_clk) disable iff (rst)
      irq_q |=> !irq_q;
  endproperty
  a_irq_one_cycle: assert property (p_irq_one_cycle) // [R2]
    else $error("done request longer than one cycle");
  property p_wide_low_zero;
    @(posedge core_clk) disable iff (rst)
      wide_q[5:0] == 6'h00;
  endproperty
  a_wide_low_zero: assert property (p_wide_low_zero) // [R9]
    else $error("wide result low bits not zero");
  property p_load_on_done;
    @(posedge core_clk) disable iff (rst)
      conv_done && gate_on |=> irq_q && narrow_q == $past(sar_final[11:4])
                               && wide_q[15:6] == $past(sar_final[11:2]);
  endproperty
  a_load_on_done: assert property (p_load_on_done) // [R8]
    else $error("results not loaded from approximation value");
  property p_same_conversion;
    @(posedge core_clk) disable iff (rst)
      irq_q |-> wide_q[15:8] == narrow_q;
  endproperty
  a_same_conversion: assert property (p_same_conversion) // [R21]
    else $error("wide and narrow results disagree");
  property p_msb_first;
    @(posedge core_clk) disable iff (rst)
      active && state_q == SAC_SAMPLE && step_end
        |=> state_q == SAC_CONVERT && sar_q == 12'h800 && idx_q == 4'hB;
  endproperty
  a_msb_first: assert property (p_msb_first) // [R7]
    else $error("conversion did not start at top bit");
  property p_bit10_trial;
    @(posedge core_clk) disable iff (rst)
      active && state_q == SAC_CONVERT && idx_q == 4'hB && step_end
        |=> sar_q[10] && sar_q[11] == $past(cmp_s2_q) && idx_q == 4'hA;
  endproperty
  a_bit10_trial: assert property (p_bit10_trial) // [R5]
    else $error("second trial bit wrong");
  property p_gate_off_defaults;
    @(posedge core_clk) disable iff (rst)
      !gate_on |=> mode_q == 8'h00 && pcfg_q == 6'h00 && chsel_q == 3'h0
                   && state_q == SAC_IDLE && !converter_clk_en;
  endproperty
  a_gate_off_defaults: assert property (p_gate_off_defaults) // [R12] [R13]
    else $error("converter not held at defaults with gate off");
  property p_run_stops;
    @(posedge core_clk) disable iff (rst)
      !run_on |=> state_q == SAC_IDLE && !sample_hold;
  endproperty
  a_run_stops: assert property (p_run_stops) // [R17]
    else $error("conversion running with run bit clear");
  property p_cmp_stops;
    @(posedge core_clk) disable iff (rst)
      !cmp_en |=> !comparator_on;
  endproperty
  a_cmp_stops: assert property (p_cmp_stops) // [R18]
    else $error("comparator powered while disabled");
endmodule // sac_top

// File: sim/sac_analog_src.sv
/*
  Analog source model: the selected input level, a sample and hold, and
  the voltage comparator against the tap chosen by the sequencer.
  Assumes levels are given in tap units and change only while stopped.
*/
`timescale 1ns/1ps

module sac_analog_src (
  input  wire logic        core_clk,        // model clock
  input  wire logic [11:0] level,           // selected input, tap units
  input  wire logic [11:0] tap_code,        // tap from the sequencer
  input  wire logic        sample_hold,     // track while high
  input  wire logic        comparator_on,   // comparator powered
  output logic             cmp_at_or_above  // comparator decision
);
  logic [11:0] held_q = 12'h000;
  logic        junk_q = 1'h0;

  // held value frozen once the sample phase ends
  always_ff @(posedge core_clk) begin
    if (sample_hold) begin
      held_q <= level;
    end
    junk_q <= ~junk_q;
  end

  // an unpowered comparator gives no usable decision
  assign cmp_at_or_above = comparator_on ? (held_q >= tap_code) : junk_q;
endmodule // sac_analog_src

// File: sim/sac_top_tb.sv
/*
  Testbench of sac_top: register tasks over AXI4-Lite, conversions at
  fixed input levels, gate and stop checks.
  Assumes sac_pkg, sac_top and the analog source model compile first.
*/
`timescale 1ns/1ps
`include "sac_regs.svh"

module sac_top_tb;
  localparam int STEP = 4;
  localparam int CONV = 13 * STEP + 1;
  logic        core_clk = 1'h0;
  logic        rst = 1'h1;
  logic [19:0] s_axi_awaddr = 20'h0, s_axi_araddr = 20'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, cmp_at_or_above, sample_hold, comparator_on;
  logic        converter_clk_en, conversion_done_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] tap_code, level = 12'h000;
  logic [5:0]  analog_inputs;
  logic [11:0] levels [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C};
  int          miscompares = 0, n_tests = 0;

  always #25 core_clk = ~core_clk;

  sac_top #(.STEP_CYCLES(STEP)) sac_top_i (
    .core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmp_at_or_above, .tap_code,
    .sample_hold, .analog_inputs, .comparator_on, .converter_clk_en,
    .conversion_done_irq);

  sac_analog_src sac_analog_src_i (.core_clk, .level, .tap_code,
    .sample_hold, .comparator_on, .cmp_at_or_above);

  // ----------------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------------
  task automatic stop_test;
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic timeout;
    miscompares++;
    $display("FAIL %0t wait ran out", $time);
    stop_test();
  endtask

  // ----------------------------------------------------------------------
  // bus and wait tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [19:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (n == 100) timeout();
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, `SAC_RESP_OKAY}, "write resp");
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] exp,
                    input logic [1:0] er, input string what);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    if (n == 100) timeout();
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, exp, what);
    chk({30'h0, s_axi_rresp}, {30'h0, er}, what);
  endtask

  task automatic wait_out(input int lim, input bit hold, input logic val);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge core_clk);
      #1;
      if ((hold ? sample_hold : conversion_done_irq) === val) break;
    end
    if (n == lim) timeout();
  endtask

  task automatic count_done(input int lim);
    int c = 0;
    repeat (lim) begin
      @(posedge core_clk);
      #1;
      if (conversion_done_irq !== 1'h0) c++;
    end
    chk(c, 0, "done pulse while stopped");
  endtask

  // stop, change the input, restart, check one finished conversion and wait for the next
  task automatic conv(input logic [11:0] v);
    wr(`SAC_OFS_MODE, 32'h01, 4'h1);
    level <= v;
    repeat (20) @(posedge core_clk);
    wr(`SAC_OFS_MODE, 32'h81, 4'h1);
    wait_out(40, 1'h1, 1'h1);
    wait_out(40, 1'h1, 1'h0);
    chk(tap_code, 12'h800, "first trial");
    repeat (STEP) @(posedge core_clk);
    #1;
    chk(tap_code[11:10], {v[11], 1'h1}, "second trial");
    wait_out(CONV, 1'h0, 1'h1);
    @(posedge core_clk);
    #1;
    chk(conversion_done_irq, 1'h0, "done pulse width");
    rd(`SAC_OFS_RWIDE, {v[11:2], 6'h00}, 2'h0, "wide");
    rd(`SAC_OFS_RNARROW, v[11:4], 2'h0, "narrow");
    wait_out(CONV + 8, 1'h0, 1'h1);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    repeat (2) @(posedge core_clk);
    chk(converter_clk_en, 1'h0, "clock gated at reset");
    rd(`SAC_OFS_GATE, 32'h0, 2'h0, "gate reset");
    rd(`SAC_OFS_MODE, 32'h0, 2'h0, "mode reset");
    rd(20'hF0114, 32'h0, `SAC_RESP_SLVERR, "unmapped");
    wr(`SAC_OFS_MODE, 32'h81, 4'h1);
    wr(`SAC_OFS_PCFG, 32'h3F, 4'h1);
    rd(`SAC_OFS_MODE, 32'h0, 2'h0, "mode gated");
    rd(`SAC_OFS_PCFG, 32'h0, 2'h0, "pcfg gated");
    wr(`SAC_OFS_GATE, 32'h20, 4'h1);
    rd(`SAC_OFS_GATE, 32'h20, 2'h0, "gate on");
    wr(`SAC_OFS_PCFG, 32'h15, 4'h1);
    rd(`SAC_OFS_PCFG, 32'h15, 2'h0, "pcfg");
    chk(analog_inputs, 6'h01, "analog pins");
    chk(converter_clk_en, 1'h1, "clock on");
    wr(`SAC_OFS_CHSEL, 32'h5, 4'h1);
    rd(`SAC_OFS_CHSEL, 32'h5, 2'h0, "channel");
    wr(`SAC_OFS_MODE, 32'h01, 4'h0);
    rd(`SAC_OFS_MODE, 32'h0, 2'h0, "no strobe");
    wr(`SAC_OFS_MODE, 32'h01, 4'h1);
    rd(`SAC_OFS_MODE, 32'h01, 2'h0, "mode");
    chk(comparator_on, 1'h1, "comparator on");
    foreach (levels[i]) conv(levels[i]);
    wr(`SAC_OFS_MODE, 32'h01, 4'h1);
    count_done(CONV + 20);
    wr(`SAC_OFS_MODE, 32'h80, 4'h1);
    @(posedge core_clk);
    chk(comparator_on, 1'h0, "comparator off");
    count_done(CONV + 20);
    wr(`SAC_OFS_GATE, 32'h00, 4'h1);
    rd(`SAC_OFS_RWIDE, 32'h0, 2'h0, "wide gated");
    wr(`SAC_OFS_GATE, 32'h20, 4'h1);
    rd(`SAC_OFS_PCFG, 32'h0, 2'h0, "pcfg reinit");
    rd(`SAC_OFS_MODE, 32'h0, 2'h0, "mode reinit");
    chk(analog_inputs, 6'h00, "pins back to port");
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    timeout();
  end
endmodule // sac_top_tb
